// [mpm_defines.svh]
// constants for the mii port mac-side block
`ifndef MPM_DEFINES_SVH
`define MPM_DEFINES_SVH

// crossing depth is 2**MPM_XFER_AW words
`define MPM_XFER_AW 2
`define MPM_NIB_W 4

// receive word layout
`define MPM_RXW 8
`define MPM_RX_FIRST 4
`define MPM_RX_LAST 5
`define MPM_RX_ERR 6
`define MPM_RX_FC 7

// transmit word layout
`define MPM_TXW 6
`define MPM_TX_LAST 4
`define MPM_TX_ERR 5

// nibble seen with error and no valid that marks a false carrier
`define MPM_FALSE_CARRIER 4'he
`define MPM_IDLE_NIBBLE 4'h0

// indicator levels, active low
`define MPM_LED_ON 1'b0
`define MPM_LED_OFF 1'b1

`endif

// [mpm_pkg.sv]
// types for the mii port mac-side block
package mpm_pkg;
  typedef logic [3:0] mpm_nibble_t;
  typedef enum logic [1:0] {MPM_TX_IDLE, MPM_TX_SEND, MPM_TX_DRAIN} mpm_tx_state_t;
endpackage

// [mpm_stream_if.sv]
// valid/ready word stream between the port's own modules
`timescale 1ns/1ps
interface mpm_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [mpm_xfer.sv]
// dual-clock word crossing with gray-coded pointers
`timescale 1ns/1ps
`include "mpm_defines.svh"
module mpm_xfer #(
  parameter int W = 8
) (
  // write domain
  input wire logic wr_clk,
  input wire logic wr_rst,
  mpm_stream_if.snk wr,
  // read domain
  input wire logic rd_clk,
  input wire logic rd_rst,
  mpm_stream_if.src rd
);
  import mpm_pkg::*;
  localparam int AW = `MPM_XFER_AW;
  localparam int DEPTH = 1 << AW;

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wbin, wgray, next_wbin, next_wgray;
  logic [AW:0] rbin, rgray, next_rbin, next_rgray;
  logic [AW:0] rg1, rg2, wg1, wg2;
  logic full, empty, wr_fire, rd_fire;

  assign full = (wgray == {~rg2[AW:AW-1], rg2[AW-2:0]});
  assign empty = (rgray == wg2);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rbin[AW-1:0]];
  assign wr_fire = wr.valid && !full;
  assign rd_fire = rd.ready && !empty;

  always_comb begin
    next_wbin = wbin + {{AW{1'b0}}, wr_fire};
    next_wgray = next_wbin ^ (next_wbin >> 1);
    next_rbin = rbin + {{AW{1'b0}}, rd_fire};
    next_rgray = next_rbin ^ (next_rbin >> 1);
  end

  always_ff @(posedge wr_clk) begin
    if (wr_fire) begin
      mem[wbin[AW-1:0]] <= wr.data;
    end
    if (wr_rst) begin
      wbin <= '0;
      wgray <= '0;
      rg1 <= '0;
      rg2 <= '0;
    end else begin
      wbin <= next_wbin;
      wgray <= next_wgray;
      rg1 <= rgray;
      rg2 <= rg1;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin <= '0;
      rgray <= '0;
      wg1 <= '0;
      wg2 <= '0;
    end else begin
      rbin <= next_rbin;
      rgray <= next_rgray;
      wg1 <= wgray;
      wg2 <= wg1;
    end
  end

  AST_NO_OVERWRITE: assert property (@(posedge wr_clk) disable iff (wr_rst)
    full |=> wbin == $past(wbin))
    else $error("write pointer moved while full");
endmodule

// [mpm_port.sv]
// mac-side mii port: receive and transmit nibble streams, status, indicators
//
// Summary of operation
// - activity indicator low while transmitting or receiving, high otherwise.
// - four-bit receive nibbles taken on the rising receive clock edge.
// - error with no valid and the marker nibble means false carrier.
// - four-bit transmit nibbles driven for the rising transmit clock edge.
// - transmit-enable rises with the first preamble nibble, falls after the last.
// - transmit-error, only with enable, forces an invalid symbol in the frame.
`timescale 1ns/1ps
`include "mpm_defines.svh"
module mpm_port (
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // core control and status
  input wire logic link_up,
  input wire logic half_duplex,
  output logic carrier_sense,
  output logic collision,
  output logic rx_dropped,
  // transmit stream from the mac core
  input wire logic tx_valid,
  output logic tx_ready,
  input wire mpm_pkg::mpm_nibble_t tx_nibble,
  input wire logic tx_last,
  input wire logic tx_error,
  // receive stream to the mac core
  output logic rx_valid,
  input wire logic rx_ready,
  output mpm_pkg::mpm_nibble_t rx_nibble,
  output logic rx_first,
  output logic rx_last,
  output logic rx_error,
  output logic rx_false_carrier,
  // phy receive side
  input wire logic port1_receive_clock,
  input wire mpm_pkg::mpm_nibble_t port1_receive_nibble,
  input wire logic port1_receive_valid,
  input wire logic port1_receive_error,
  input wire logic port1_carrier_sense,
  input wire logic port1_collision_in,
  // phy transmit side
  input wire logic port1_transmit_clock,
  output mpm_pkg::mpm_nibble_t port1_transmit_nibble,
  output logic port1_transmit_enable,
  output logic port1_transmit_error,
  // indicators
  output logic port1_link_indicator_n,
  output logic port1_activity_indicator_n
);
  import mpm_pkg::*;

  mpm_stream_if #(.W(`MPM_TXW)) tx_in ();
  mpm_stream_if #(.W(`MPM_TXW)) tx_out ();
  mpm_stream_if #(.W(`MPM_RXW)) rx_in ();
  mpm_stream_if #(.W(`MPM_RXW)) rx_out ();

  // reset carried into each link domain
  logic rrst1, rx_rst, trst1, tx_rst;
  always_ff @(posedge port1_receive_clock) begin
    rrst1 <= reset;
    rx_rst <= rrst1;
  end
  always_ff @(posedge port1_transmit_clock) begin
    trst1 <= reset;
    tx_rst <= trst1;
  end

  mpm_xfer #(.W(`MPM_TXW)) u_tx_xfer (
    .wr_clk(core_clk),
    .wr_rst(reset),
    .wr(tx_in),
    .rd_clk(port1_transmit_clock),
    .rd_rst(tx_rst),
    .rd(tx_out)
  );

  mpm_xfer #(.W(`MPM_RXW)) u_rx_xfer (
    .wr_clk(port1_receive_clock),
    .wr_rst(rx_rst),
    .wr(rx_in),
    .rd_clk(core_clk),
    .rd_rst(reset),
    .rd(rx_out)
  );

  assign tx_in.valid = tx_valid;
  assign tx_in.data = {tx_error, tx_last, tx_nibble};
  assign tx_ready = tx_in.ready;

  assign rx_valid = rx_out.valid;
  assign rx_out.ready = rx_ready;
  assign rx_nibble = rx_out.data[`MPM_NIB_W-1:0];
  assign rx_first = rx_out.data[`MPM_RX_FIRST];
  assign rx_last = rx_out.data[`MPM_RX_LAST];
  assign rx_error = rx_out.data[`MPM_RX_ERR];
  assign rx_false_carrier = rx_out.data[`MPM_RX_FC];

  // ---------------- receive domain ----------------
  mpm_nibble_t rxd_q, prev_nib, next_prev_nib;
  logic dv_q, er_q, have_prev, next_have_prev, prev_first, next_prev_first;
  logic prev_err, next_prev_err, drop_tgl, next_drop_tgl;
  logic push;
  logic [`MPM_RXW-1:0] push_word;
  logic fc_seen;

  assign fc_seen = !dv_q && er_q && (rxd_q == `MPM_FALSE_CARRIER);

  // one nibble is held back so the final one can carry the last mark
  always_comb begin
    next_prev_nib = prev_nib;
    next_prev_first = prev_first;
    next_prev_err = prev_err;
    next_have_prev = have_prev;
    next_drop_tgl = drop_tgl;
    push = 1'b0;
    push_word = '0;
    if (have_prev) begin
      push = 1'b1;
      push_word = {1'b0, prev_err, !dv_q, prev_first, prev_nib};
    end else if (fc_seen) begin
      push = 1'b1;
      push_word = {1'b1, 1'b0, 1'b0, 1'b0, rxd_q};
    end
    if (dv_q) begin
      next_prev_nib = rxd_q;
      next_prev_first = !have_prev;
      next_prev_err = er_q;
      next_have_prev = 1'b1;
    end else begin
      next_have_prev = 1'b0;
    end
    if (push && !rx_in.ready) begin
      next_drop_tgl = !drop_tgl;
    end
  end

  assign rx_in.valid = push;
  assign rx_in.data = push_word;

  always_ff @(posedge port1_receive_clock) begin
    rxd_q <= port1_receive_nibble;
    dv_q <= port1_receive_valid;
    er_q <= port1_receive_error;
    prev_nib <= next_prev_nib;
    prev_first <= next_prev_first;
    prev_err <= next_prev_err;
    if (rx_rst) begin
      have_prev <= 1'b0;
      drop_tgl <= 1'b0;
    end else begin
      have_prev <= next_have_prev;
      drop_tgl <= next_drop_tgl;
    end
  end

  // ---------------- transmit domain ----------------
  mpm_tx_state_t tx_state, next_tx_state;
  mpm_nibble_t next_txd;
  logic next_txen, next_txer;
  logic crs_t1, crs_t2, col_t1, col_t2, hd_t1, hd_t2;
  logic tx_pop, defer;
  logic w_last, w_err;

  always_ff @(posedge port1_transmit_clock) begin
    crs_t1 <= port1_carrier_sense;
    crs_t2 <= crs_t1;
    col_t1 <= port1_collision_in;
    col_t2 <= col_t1;
    hd_t1 <= half_duplex;
    hd_t2 <= hd_t1;
  end

  assign w_last = tx_out.data[`MPM_TX_LAST];
  assign w_err = tx_out.data[`MPM_TX_ERR];
  assign defer = hd_t2 && crs_t2;
  assign tx_out.ready = tx_pop;

  always_comb begin
    next_tx_state = tx_state;
    next_txd = `MPM_IDLE_NIBBLE;
    next_txen = 1'b0;
    next_txer = 1'b0;
    tx_pop = 1'b0;
    unique case (tx_state)
      MPM_TX_IDLE: begin
        if (tx_out.valid && !defer && !port1_transmit_enable) begin
          tx_pop = 1'b1;
          next_txd = tx_out.data[`MPM_NIB_W-1:0];
          next_txen = 1'b1;
          next_txer = w_err;
          next_tx_state = w_last ? MPM_TX_IDLE : MPM_TX_SEND;
        end
      end
      MPM_TX_SEND: begin
        next_txen = 1'b1;
        if (tx_out.valid) begin
          tx_pop = 1'b1;
          next_txd = tx_out.data[`MPM_NIB_W-1:0];
          next_txer = w_err || (hd_t2 && col_t2);
          if (w_last) begin
            next_tx_state = MPM_TX_IDLE;
          end else if (hd_t2 && col_t2) begin
            next_tx_state = MPM_TX_DRAIN;
          end
        end else begin
          // underrun: poison the frame and end it
          next_txer = 1'b1;
          next_tx_state = MPM_TX_DRAIN;
        end
      end
      MPM_TX_DRAIN: begin
        tx_pop = 1'b1;
        if (tx_out.valid && w_last) begin
          next_tx_state = MPM_TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge port1_transmit_clock) begin
    if (tx_rst) begin
      tx_state <= MPM_TX_IDLE;
      port1_transmit_nibble <= `MPM_IDLE_NIBBLE;
      port1_transmit_enable <= 1'b0;
      port1_transmit_error <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      port1_transmit_nibble <= next_txd;
      port1_transmit_enable <= next_txen;
      port1_transmit_error <= next_txer;
    end
  end

  // ---------------- core domain status ----------------
  logic crs_c1, crs_c2, col_c1, col_c2;
  logic act_tx1, act_tx2, act_rx1, act_rx2;
  logic drop1, drop2, drop3;
  logic next_link_n, next_act_n, next_dropped;

  always_comb begin
    next_link_n = link_up ? `MPM_LED_ON : `MPM_LED_OFF;
    next_act_n = (act_tx2 || act_rx2) ? `MPM_LED_ON : `MPM_LED_OFF;
    next_dropped = drop2 ^ drop3;
  end

  always_ff @(posedge core_clk) begin
    crs_c1 <= port1_carrier_sense;
    crs_c2 <= crs_c1;
    col_c1 <= port1_collision_in;
    col_c2 <= col_c1;
    act_tx1 <= port1_transmit_enable;
    act_tx2 <= act_tx1;
    act_rx1 <= dv_q;
    act_rx2 <= act_rx1;
    drop1 <= drop_tgl;
    drop2 <= drop1;
    if (reset) begin
      drop3 <= 1'b0;
      carrier_sense <= 1'b0;
      collision <= 1'b0;
      rx_dropped <= 1'b0;
      port1_link_indicator_n <= `MPM_LED_OFF;
      port1_activity_indicator_n <= `MPM_LED_OFF;
    end else begin
      drop3 <= drop2;
      carrier_sense <= crs_c2;
      collision <= col_c2;
      rx_dropped <= next_dropped;
      port1_link_indicator_n <= next_link_n;
      port1_activity_indicator_n <= next_act_n;
    end
  end

  // ---------------- checks ----------------
  AST_LINK_LED: assert property (@(posedge core_clk) disable iff (reset)
    ##1 port1_link_indicator_n == !$past(link_up))
    else $error("link indicator does not follow link state");
  AST_ACT_ON: assert property (@(posedge core_clk) disable iff (reset)
    (act_tx2 || act_rx2) |=> port1_activity_indicator_n == 1'b0)
    else $error("activity indicator dark during traffic");
  AST_ACT_OFF: assert property (@(posedge core_clk) disable iff (reset)
    (!act_tx2 && !act_rx2) |=> port1_activity_indicator_n == 1'b1)
    else $error("activity indicator lit while idle");
  AST_RX_SAMPLE: assert property (@(posedge port1_receive_clock) disable iff (rx_rst)
    dv_q |=> have_prev && prev_nib == $past(rxd_q) && prev_first == !$past(have_prev))
    else $error("received nibble not captured");
  AST_RX_LAST: assert property (@(posedge port1_receive_clock) disable iff (rx_rst)
    (have_prev && !dv_q) |-> rx_in.valid && rx_in.data[`MPM_RX_LAST]
      && rx_in.data[`MPM_NIB_W-1:0] == prev_nib)
    else $error("frame end not marked on final nibble");
  AST_FALSE_CARRIER: assert property (@(posedge port1_receive_clock) disable iff (rx_rst)
    (!have_prev && !dv_q && er_q && rxd_q == `MPM_FALSE_CARRIER)
      |-> rx_in.valid && rx_in.data[`MPM_RX_FC])
    else $error("false carrier not reported");
  AST_TX_DATA: assert property (@(posedge port1_transmit_clock) disable iff (tx_rst)
    (tx_pop && tx_out.valid && tx_state != MPM_TX_DRAIN)
      |=> port1_transmit_enable && port1_transmit_nibble == $past(tx_out.data[3:0]))
    else $error("transmit nibble not driven");
  AST_TX_EN_HOLD: assert property (@(posedge port1_transmit_clock) disable iff (tx_rst)
    (port1_transmit_enable && tx_state == MPM_TX_SEND) |=> port1_transmit_enable)
    else $error("transmit enable dropped inside a frame");
  AST_TX_GAP: assert property (@(posedge port1_transmit_clock) disable iff (tx_rst)
    (port1_transmit_enable && tx_state == MPM_TX_IDLE) |=> !port1_transmit_enable)
    else $error("frames sent without an idle nibble between them");
  AST_TX_ERR_EN: assert property (@(posedge port1_transmit_clock) disable iff (tx_rst)
    port1_transmit_error |-> port1_transmit_enable)
    else $error("transmit error without enable");
  AST_TX_UNDERRUN: assert property (@(posedge port1_transmit_clock) disable iff (tx_rst)
    (tx_state == MPM_TX_SEND && !tx_out.valid) |=> port1_transmit_error ##1 !port1_transmit_enable)
    else $error("underrun not poisoned");
  AST_TX_DEFER: assert property (@(posedge port1_transmit_clock) disable iff (tx_rst)
    (tx_state == MPM_TX_IDLE && defer) |=> !port1_transmit_enable)
    else $error("transmit started over carrier in half duplex");

  COV_TX_FRAME: cover property (@(posedge port1_transmit_clock) disable iff (tx_rst)
    tx_state == MPM_TX_SEND ##1 tx_state == MPM_TX_IDLE);
  COV_TX_ABORT: cover property (@(posedge port1_transmit_clock) disable iff (tx_rst)
    tx_state == MPM_TX_DRAIN);
  COV_RX_FRAME: cover property (@(posedge port1_receive_clock) disable iff (rx_rst)
    dv_q ##1 dv_q ##1 !dv_q);
  COV_RX_FC: cover property (@(posedge port1_receive_clock) disable iff (rx_rst)
    fc_seen && !have_prev);
endmodule

// [mpm_phy_model.sv]
// phy model on the far side of the port's mii pins
`timescale 1ns/1ps
module mpm_phy_model (
  // receive pins
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rxdv,
  output logic rxer,
  output logic crs,
  output logic col,
  // transmit pins
  output logic tx_clk,
  input wire logic [3:0] txd,
  input wire logic txen,
  input wire logic txer
);
  logic [4:0] tx_seen[$];
  int tx_frames = 0;
  logic was_en = 1'b0;
  initial begin
    rx_clk = 1'b0;
    tx_clk = 1'b0;
    rxd = 4'h0;
    rxdv = 1'b0;
    rxer = 1'b0;
    crs = 1'b0;
    col = 1'b0;
  end
  // free running 48 ns clocks, phases unrelated
  always #24 rx_clk = ~rx_clk;
  initial #7 forever #24 tx_clk = ~tx_clk;
  // nibbles taken on the rising transmit edge; a frame ends when enable drops
  always @(posedge tx_clk) begin
    if (txen === 1'b1) tx_seen.push_back({txer, txd});
    if (was_en === 1'b1 && txen === 1'b0) tx_frames++;
    was_en = txen;
  end
  // pins change on the falling edge so they are settled at the rising one
  task automatic send_rx(input logic [4:0] w[$]);
    foreach (w[i]) begin
      @(negedge rx_clk);
      rxdv = 1'b1;
      rxd = w[i][3:0];
      rxer = w[i][4];
    end
    @(negedge rx_clk);
    rxdv = 1'b0;
    rxd = ~rxd;
  endtask
  // error without valid, marker nibble on the bus
  task automatic false_carrier;
    @(negedge rx_clk);
    rxer = 1'b1;
    rxd = 4'he;
    @(negedge rx_clk);
    rxer = 1'b0;
    rxd = ~rxd;
  endtask
  task automatic set_status(input logic c, input logic k);
    crs = c;
    col = k;
  endtask
endmodule

// [mii_port_mac_side_bench.sv]
// self-checking bench for the mac-side mii port
`timescale 1ns/1ps
module mii_port_mac_side_bench;
  import mpm_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic link_up = 1'b0;
  logic half_duplex = 1'b0;
  logic tx_valid = 1'b0;
  mpm_nibble_t tx_nibble = 4'h0;
  logic tx_last = 1'b0;
  logic tx_error = 1'b0;
  logic rx_ready = 1'b1;
  logic carrier_sense, collision, rx_dropped, tx_ready, rx_valid;
  logic rx_first, rx_last, rx_error, rx_false_carrier;
  mpm_nibble_t rx_nibble, rxd, txd;
  logic rx_clk, rxdv, rxer, crs, col, tx_clk, txen, txer, link_n, act_n;
  int n_mismatch = 0;
  int check_count = 0;
  int n_drop = 0;
  int base_tx, base_rx, base_drop;
  logic [7:0] rx_seen[$];
  // transmit rows: {last, error, nibble}, seen on the wire as {error, nibble}
  logic [5:0] rows[8] = '{6'h05, 6'h05, 6'h05, 6'h05, 6'h0d, 6'h1a, 6'h23, 6'h27};

  always #5 core_clk = ~core_clk;

  mpm_port mpm_port_inst (.core_clk(core_clk), .reset(reset), .link_up(link_up),
    .half_duplex(half_duplex), .carrier_sense(carrier_sense), .collision(collision),
    .rx_dropped(rx_dropped), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_nibble(tx_nibble), .tx_last(tx_last), .tx_error(tx_error),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_nibble(rx_nibble),
    .rx_first(rx_first), .rx_last(rx_last), .rx_error(rx_error),
    .rx_false_carrier(rx_false_carrier), .port1_receive_clock(rx_clk),
    .port1_receive_nibble(rxd), .port1_receive_valid(rxdv),
    .port1_receive_error(rxer), .port1_carrier_sense(crs),
    .port1_collision_in(col), .port1_transmit_clock(tx_clk),
    .port1_transmit_nibble(txd), .port1_transmit_enable(txen),
    .port1_transmit_error(txer), .port1_link_indicator_n(link_n),
    .port1_activity_indicator_n(act_n));

  mpm_phy_model mpm_phy_model_inst (.rx_clk(rx_clk), .rxd(rxd), .rxdv(rxdv),
    .rxer(rxer), .crs(crs), .col(col), .tx_clk(tx_clk), .txd(txd),
    .txen(txen), .txer(txer));

  // drop pulses counted; words leave the stream at the edge after a settled valid
  always @(negedge core_clk) begin
    if (rx_dropped === 1'b1)
      n_drop++;
    #1;
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      rx_seen.push_back({rx_false_carrier, rx_error, rx_last, rx_first, rx_nibble});
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // called at a falling edge; valid stays up between words
  task automatic push_tx(input logic [5:0] w);
    int t;
    t = 0;
    tx_valid = 1'b1;
    tx_nibble = w[3:0];
    tx_error = w[4];
    tx_last = w[5];
    while (tx_ready !== 1'b1 && t < 3000) begin
      @(negedge core_clk);
      t++;
    end
    @(negedge core_clk);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    // link clocks need three edges inside reset
    repeat (15) @(negedge core_clk);
    check("link led in reset", 8'h1, {7'h0, link_n});
    check("act led in reset", 8'h1, {7'h0, act_n});
    check("tx enable in reset", 8'h0, {7'h0, txen});
    reset = 1'b0;
    $display("test reset done");
    // table of transmit words, two frames back to back
    fork
      for (int i = 0; i < 8; i++) push_tx(rows[i]);
      begin
        for (int t = 0; t < 500 && txen !== 1'b1; t++) @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        check("act led sending", 8'h0, {7'h0, act_n});
      end
    join
    tx_valid = 1'b0;
    for (int t = 0; t < 1000 && mpm_phy_model_inst.tx_seen.size() < 8; t++)
      @(negedge core_clk);
    repeat (20) @(negedge core_clk);
    check("tx count", 8'd8, 8'(mpm_phy_model_inst.tx_seen.size()));
    foreach (rows[i])
      check("tx nibble", {3'h0, rows[i][4:0]}, {3'h0, mpm_phy_model_inst.tx_seen[i]});
    check("tx frames", 8'd2, 8'(mpm_phy_model_inst.tx_frames));
    check("act led idle", 8'h1, {7'h0, act_n});
    $display("test transmit done");
    // receive frame with one errored nibble, then a false carrier
    mpm_phy_model_inst.send_rx('{5'h01, 5'h12, 5'h03, 5'h04});
    repeat (40) @(negedge core_clk);
    mpm_phy_model_inst.false_carrier();
    repeat (40) @(negedge core_clk);
    check("rx count", 8'd5, 8'(rx_seen.size()));
    if (rx_seen.size() == 5) begin
      check("rx word 0", 8'h11, rx_seen[0]);
      check("rx word 1", 8'h42, rx_seen[1]);
      check("rx word 2", 8'h03, rx_seen[2]);
      check("rx word 3", 8'h24, rx_seen[3]);
      check("false carrier", 8'h8e, rx_seen[4]);
    end
    $display("test receive done");
    // link indicator follows the link level
    link_up = 1'b1;
    repeat (4) @(negedge core_clk);
    check("link led up", 8'h0, {7'h0, link_n});
    link_up = 1'b0;
    repeat (4) @(negedge core_clk);
    check("link led down", 8'h1, {7'h0, link_n});
    $display("test link done");
    // unclocked status pins change between edges
    #3;
    mpm_phy_model_inst.set_status(1'b1, 1'b1);
    repeat (6) @(negedge core_clk);
    check("carrier sense", 8'h1, {7'h0, carrier_sense});
    check("collision", 8'h1, {7'h0, collision});
    #3;
    mpm_phy_model_inst.set_status(1'b0, 1'b0);
    repeat (6) @(negedge core_clk);
    check("carrier clear", 8'h0, {7'h0, carrier_sense});
    check("collision clear", 8'h0, {7'h0, collision});
    $display("test status done");
    // underrun mid-frame poisons one nibble and discards to the frame end
    base_tx = mpm_phy_model_inst.tx_seen.size();
    push_tx(6'h01);
    tx_valid = 1'b0;
    repeat (60) @(negedge core_clk);
    push_tx(6'h25);
    tx_valid = 1'b0;
    repeat (60) @(negedge core_clk);
    check("underrun count", 8'(base_tx + 2), 8'(mpm_phy_model_inst.tx_seen.size()));
    check("underrun first", 8'h01, {3'h0, mpm_phy_model_inst.tx_seen[base_tx]});
    check("underrun poison", 8'h10, {3'h0, mpm_phy_model_inst.tx_seen[base_tx + 1]});
    check("underrun frames", 8'd3, 8'(mpm_phy_model_inst.tx_frames));
    $display("test underrun done");
    // half duplex: frame start held off while carrier is sensed
    half_duplex = 1'b1;
    mpm_phy_model_inst.set_status(1'b1, 1'b0);
    repeat (20) @(negedge core_clk);
    push_tx(6'h29);
    tx_valid = 1'b0;
    repeat (60) @(negedge core_clk);
    check("deferred", 8'(base_tx + 2), 8'(mpm_phy_model_inst.tx_seen.size()));
    mpm_phy_model_inst.set_status(1'b0, 1'b0);
    repeat (60) @(negedge core_clk);
    check("defer released", 8'h09, {3'h0, mpm_phy_model_inst.tx_seen[base_tx + 2]});
    // half duplex collision poisons the nibble and aborts the frame
    mpm_phy_model_inst.set_status(1'b0, 1'b1);
    repeat (20) @(negedge core_clk);
    push_tx(6'h01);
    push_tx(6'h02);
    push_tx(6'h23);
    tx_valid = 1'b0;
    repeat (60) @(negedge core_clk);
    check("collision count", 8'(base_tx + 5), 8'(mpm_phy_model_inst.tx_seen.size()));
    check("collision first", 8'h01, {3'h0, mpm_phy_model_inst.tx_seen[base_tx + 3]});
    check("collision poison", 8'h12, {3'h0, mpm_phy_model_inst.tx_seen[base_tx + 4]});
    check("tx frames all", 8'd5, 8'(mpm_phy_model_inst.tx_frames));
    mpm_phy_model_inst.set_status(1'b0, 1'b0);
    half_duplex = 1'b0;
    $display("test half duplex done");
    // slow sink: crossing fills, later nibbles are dropped and flagged
    base_rx = rx_seen.size();
    base_drop = n_drop;
    rx_ready = 1'b0;
    mpm_phy_model_inst.send_rx('{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06});
    repeat (40) @(negedge core_clk);
    rx_ready = 1'b1;
    repeat (20) @(negedge core_clk);
    check("rx kept", 8'(base_rx + 4), 8'(rx_seen.size()));
    check("rx kept first", 8'h11, rx_seen[base_rx]);
    check("rx kept fourth", 8'h04, rx_seen[base_rx + 3]);
    check("rx dropped", 8'h1, {7'h0, n_drop != base_drop});
    $display("test overflow done");
    give_verdict();
  end
endmodule
